// file: clkgc_pkg.sv
package clkgc_pkg;
   // System clock and nominal base clock
   localparam int unsigned CLK_HZ       = 250_000_000;
   localparam int unsigned NOM_FREQ_HZ  = 307_200;
   localparam int unsigned STEP_FREQ_HZ = NOM_FREQ_HZ / 4;
   localparam int unsigned NOM_HALF_CYC = CLK_HZ / (2 * NOM_FREQ_HZ);

   // Register bus
   localparam int          ADDR_W   = 8;
   localparam int          DATA_W   = 32;
   localparam logic [7:0]  OFS_CTRL = 8'h00;
   localparam logic [7:0]  OFS_CFG  = 8'h04;
   localparam logic [7:0]  OFS_MULT = 8'h08;
   localparam logic [7:0]  OFS_DCO  = 8'h0c;
   localparam logic [7:0]  OFS_STAT = 8'h10;

   // Field positions
   localparam int CTRL_INT_BIT  = 0;
   localparam int CTRL_EXT_BIT  = 1;
   localparam int CFG_RUN_BIT   = 0;
   localparam int CFG_EXTOK_BIT = 1;
   localparam int CFG_XTAL_BIT  = 2;
   localparam int STAT_W        = 7;

   // Reset values and widths
   localparam logic       INT_ON_RST = 1'b1;
   localparam int         MULT_W_DEF = 7;
   localparam int         DCO_W      = 12;
   localparam logic [3:0] DIV_MAX    = 4'h9;
   localparam logic [11:0] DCO_RST   = 12'h800;
   localparam int         DCO_SHIFT  = 2;
   localparam int         PER_W      = 10;

   // Loop filter correction sizes
   localparam logic [11:0] CORR_BIG   = 12'h020;
   localparam logic [11:0] CORR_MID   = 12'h008;
   localparam logic [11:0] CORR_SMALL = 12'h001;

   // Base clock half period thresholds, in system cycles
   localparam int MEAS_W = 16;
   localparam logic [15:0] LIM_S15 = 16'(NOM_HALF_CYC * 100 / 85);
   localparam logic [15:0] LIM_S05 = 16'(NOM_HALF_CYC * 100 / 95);
   localparam logic [15:0] LIM_NOM = 16'(NOM_HALF_CYC);
   localparam logic [15:0] LIM_F05 = 16'(NOM_HALF_CYC * 100 / 105);
   localparam logic [15:0] LIM_F15 = 16'(NOM_HALF_CYC * 100 / 115);

   typedef enum logic [2:0] {
      BAND_S15 = 3'b000,
      BAND_S05 = 3'b001,
      BAND_S00 = 3'b010,
      BAND_NOM = 3'b011,
      BAND_F00 = 3'b100,
      BAND_F05 = 3'b101,
      BAND_F15 = 3'b110
   } clkgc_band_t;
endpackage

// file: clkgc_top.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module clkgc_top #(
   parameter int MULT_W = clkgc_pkg::MULT_W_DEF
) (
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           reset,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [clkgc_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [clkgc_pkg::DATA_W-1:0]   pwdata,
   output logic      [clkgc_pkg::DATA_W-1:0]   prdata,
   output logic                                pready,
   output logic                                pslverr,
   // Mode and pin
   input  wire logic                           stop_mode,
   input  wire logic                           ext_clk_pin,
   // Clock levels and bus enable
   output logic                                internal_clock,
   output logic                                base_clock,
   output logic                                external_clock,
   output logic                                osc_out_clock,
   output logic                                gen_out_clock,
   output logic                                bus_clock_en,
   output logic                                timebase_clock,
   output logic                                watchdog_clock,
   // Enables and status
   output logic                                gen_stop,
   output logic                                int_gen_enable,
   output logic                                ext_gen_enable,
   output logic                                pin_osc1_port_en,
   output logic                                pin_osc2_port_en,
   output logic                                filter_stable_flag
);
   import clkgc_pkg::*;

   logic                int_on_r;
   logic                ext_on_r;
   logic                run_stop_r;
   logic                ext_ok_r;
   logic                xtal_r;
   logic [MULT_W-1:0]   mult_r;
   logic [DCO_W-1:0]    dco_r;
   logic [DATA_W-1:0]   prdata_r;
   logic [DATA_W-1:0]   rdata_nxt;
   logic                addr_ok;
   logic                wr_en;
   logic [3:0]          dco_divider_ctl_eff;
   logic [PER_W-1:0]    period;
   logic [PER_W-1:0]    per_cnt_r;
   logic                int_tick;
   logic                internal_clock_r;
   logic [MULT_W-1:0]   div_cnt_r;
   logic                bypass;
   logic                base_tick;
   logic                base_clock_r;
   logic [MEAS_W-1:0]   meas_r;
   clkgc_band_t         band;
   logic [DCO_W-1:0]    dco_nxt;
   logic                stable_r;
   logic                ext_s1_r;
   logic                ext_s2_r;
   logic                external_clock_r;
   logic                ext_rise;
   logic                osc_rise;
   logic [1:0]          gen_cnt_r;

   // Enable logic
   assign gen_stop         = stop_mode & ~run_stop_r;
   assign int_gen_enable   = int_on_r & ~gen_stop;
   assign ext_gen_enable   = ext_on_r & ~gen_stop;
   assign pin_osc1_port_en = ~ext_on_r;
   assign pin_osc2_port_en = ~(ext_on_r & xtal_r);

   // APB decode: no wait states, error on unmapped address
   assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_CFG) || (paddr == OFS_MULT)
                    || (paddr == OFS_DCO) || (paddr == OFS_STAT);
   assign wr_en   = psel & penable & pwrite & addr_ok;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata  = prdata_r;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         int_on_r <= INT_ON_RST;
         ext_on_r <= 1'b0;
      end else if (wr_en && paddr == OFS_CTRL) begin
         int_on_r <= pwdata[CTRL_INT_BIT];
         if (ext_ok_r || !pwdata[CTRL_EXT_BIT]) begin
            ext_on_r <= pwdata[CTRL_EXT_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         run_stop_r <= 1'b0;
         ext_ok_r   <= 1'b0;
         xtal_r     <= 1'b0;
      end else if (wr_en && paddr == OFS_CFG) begin
         run_stop_r <= pwdata[CFG_RUN_BIT];
         ext_ok_r   <= pwdata[CFG_EXTOK_BIT];
         xtal_r     <= pwdata[CFG_XTAL_BIT];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mult_r <= MULT_W'(1);
      end else if (wr_en && paddr == OFS_MULT) begin
         mult_r <= pwdata[MULT_W-1:0];
      end
   end

   always_comb begin
      rdata_nxt = '0;
      case (paddr)
         OFS_CTRL: begin
            rdata_nxt[CTRL_INT_BIT] = int_on_r;
            rdata_nxt[CTRL_EXT_BIT] = ext_on_r;
         end
         OFS_CFG: begin
            rdata_nxt[CFG_RUN_BIT]   = run_stop_r;
            rdata_nxt[CFG_EXTOK_BIT] = ext_ok_r;
            rdata_nxt[CFG_XTAL_BIT]  = xtal_r;
         end
         OFS_MULT: rdata_nxt[MULT_W-1:0] = mult_r;
         OFS_DCO:  rdata_nxt[DCO_W-1:0]  = dco_r;
         OFS_STAT: rdata_nxt[STAT_W-1:0] = {pin_osc2_port_en, pin_osc1_port_en,
                                            ext_gen_enable, int_gen_enable,
                                            gen_stop, xtal_r, stable_r};
         default:  rdata_nxt = '0;
      endcase
   end

   // Read data is captured in the setup cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prdata_r <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rdata_nxt;
      end
   end

   // Oscillator: period in system cycles follows the control word
   assign dco_divider_ctl_eff = (dco_r[11:8] > DIV_MAX) ? DIV_MAX : dco_r[11:8];
   assign period   = PER_W'({dco_divider_ctl_eff, dco_r[7:0]} >> DCO_SHIFT);
   assign int_tick = int_gen_enable && (per_cnt_r >= period);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         per_cnt_r <= '0;
      end else if (!int_gen_enable || int_tick) begin
         per_cnt_r <= '0;
      end else begin
         per_cnt_r <= per_cnt_r + PER_W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         internal_clock_r <= 1'b0;
      end else if (!int_gen_enable) begin
         internal_clock_r <= 1'b0;
      end else if (int_tick) begin
         internal_clock_r <= ~internal_clock_r;
      end
   end

   // Modulo N divider
   assign bypass    = (mult_r <= MULT_W'(1));
   assign base_tick = int_tick && (bypass || div_cnt_r >= mult_r - MULT_W'(1));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div_cnt_r <= '0;
      end else if (!int_gen_enable || base_tick) begin
         div_cnt_r <= '0;
      end else if (int_tick) begin
         div_cnt_r <= div_cnt_r + MULT_W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         base_clock_r <= 1'b0;
      end else if (!int_gen_enable) begin
         base_clock_r <= 1'b0;
      end else if (base_tick) begin
         base_clock_r <= ~base_clock_r;
      end
   end

   // Frequency comparator: half period of the base clock in system cycles
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         meas_r <= '0;
      end else if (!int_gen_enable || base_tick) begin
         meas_r <= '0;
      end else if (meas_r != '1) begin
         meas_r <= meas_r + MEAS_W'(1);
      end
   end

   always_comb begin
      if (meas_r > LIM_S15) begin
         band = BAND_S15;
      end else if (meas_r > LIM_S05) begin
         band = BAND_S05;
      end else if (meas_r > LIM_NOM) begin
         band = BAND_S00;
      end else if (meas_r == LIM_NOM) begin
         band = BAND_NOM;
      end else if (meas_r >= LIM_F05) begin
         band = BAND_F00;
      end else if (meas_r >= LIM_F15) begin
         band = BAND_F05;
      end else begin
         band = BAND_F15;
      end
   end

   // Loop filter: slow base clock shortens the period, fast lengthens it
   always_comb begin
      case (band)
         BAND_S15: dco_nxt = dco_r - CORR_BIG;
         BAND_S05: dco_nxt = dco_r - CORR_MID;
         BAND_S00: dco_nxt = dco_r - CORR_SMALL;
         BAND_F00: dco_nxt = dco_r + CORR_SMALL;
         BAND_F05: dco_nxt = dco_r + CORR_MID;
         BAND_F15: dco_nxt = dco_r + CORR_BIG;
         default:  dco_nxt = dco_r;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dco_r <= DCO_RST;
      end else if (base_tick) begin
         dco_r <= dco_nxt;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stable_r <= 1'b0;
      end else if (!int_gen_enable) begin
         stable_r <= 1'b0;
      end else if (base_tick) begin
         stable_r <= (band == BAND_S00) || (band == BAND_NOM) || (band == BAND_F00);
      end
   end

   // External clock pin synchroniser
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_clk_pin;
         ext_s2_r <= ext_s1_r;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         external_clock_r <= 1'b0;
      end else begin
         external_clock_r <= ext_gen_enable & ext_s2_r;
      end
   end

   assign ext_rise = ext_gen_enable & ext_s2_r & ~external_clock_r;

   // Source select and bus rate divider
   assign osc_rise = ext_gen_enable ? ext_rise : (int_tick & ~internal_clock_r);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         gen_cnt_r <= 2'h0;
      end else if (osc_rise) begin
         gen_cnt_r <= gen_cnt_r + 2'h1;
      end
   end

   assign internal_clock     = internal_clock_r;
   assign base_clock         = base_clock_r;
   assign external_clock     = external_clock_r;
   assign osc_out_clock      = ext_gen_enable ? external_clock_r : internal_clock_r;
   assign gen_out_clock      = gen_cnt_r[0];
   assign bus_clock_en       = osc_rise && (gen_cnt_r == 2'h3);
   assign timebase_clock     = ext_gen_enable ? external_clock_r : internal_clock_r;
   assign watchdog_clock     = osc_out_clock;
   assign filter_stable_flag = stable_r;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   property p_stop_halts;
      stop_mode && !run_stop_r |-> gen_stop && !int_gen_enable && !ext_gen_enable;
   endproperty
   a_stop_halts: assert property (p_stop_halts) else $error("clocks not halted in stop");

   property p_run_in_stop;
      run_stop_r && int_on_r |-> int_gen_enable && !gen_stop;
   endproperty
   a_run_in_stop: assert property (p_run_in_stop) else $error("clock halted despite run");

   property p_int_low;
      !int_gen_enable |=> !internal_clock && !base_clock;
   endproperty
   a_int_low: assert property (p_int_low) else $error("internal clocks not low");

   property p_ext_low;
      !ext_gen_enable |=> !external_clock;
   endproperty
   a_ext_low: assert property (p_ext_low) else $error("external clock not low");

   property p_ext_guard;
      wr_en && paddr == OFS_CTRL && pwdata[CTRL_EXT_BIT] && !ext_ok_r && !ext_on_r
         |=> !ext_on_r;
   endproperty
   a_ext_guard: assert property (p_ext_guard) else $error("external-on set while barred");

   property p_pin1;
      ext_on_r |-> !pin_osc1_port_en;
   endproperty
   a_pin1: assert property (p_pin1) else $error("first pin port enabled");

   property p_pin2;
      ext_on_r && xtal_r |-> !pin_osc2_port_en;
   endproperty
   a_pin2: assert property (p_pin2) else $error("second pin port enabled");

   property p_div_clamp;
      int_gen_enable && dco_r[11:8] > DIV_MAX
         |-> period == PER_W'({DIV_MAX, dco_r[7:0]} >> DCO_SHIFT);
   endproperty
   a_div_clamp: assert property (p_div_clamp) else $error("divider not clamped");

   property p_bypass;
      int_tick && bypass |=> base_clock != $past(base_clock);
   endproperty
   a_bypass: assert property (p_bypass) else $error("divider not bypassed");

   property p_bus_quarter;
      bus_clock_en |=> !bus_clock_en [*2];
   endproperty
   a_bus_quarter: assert property (p_bus_quarter) else $error("bus enable too close");

   c_ext_on: cover property (ext_gen_enable && bus_clock_en);
   c_run_stop: cover property (stop_mode && run_stop_r && int_tick);
   c_stable: cover property (!filter_stable_flag ##1 filter_stable_flag);
endmodule

// file: clkgc_far_model.sv
`timescale 1ns/10ps
module clkgc_far_model #(
   parameter int HALF = 7
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // Requests from the bench
   input  wire logic want_stop,
   input  wire logic osc_run,
   // Toward the block
   output logic      stop_mode,
   output logic      ext_clk_pin
);
   logic [7:0] half_cnt_r;

   // System logic enters and leaves stop mode on a clock edge
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stop_mode <= 1'b0;
      end else begin
         stop_mode <= want_stop;
      end
   end

   // External source runs only while asked and stands low otherwise
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         half_cnt_r  <= 8'h00;
         ext_clk_pin <= 1'b0;
      end else if (!osc_run) begin
         half_cnt_r  <= 8'h00;
         ext_clk_pin <= 1'b0;
      end else if (half_cnt_r == 8'(HALF - 1)) begin
         half_cnt_r  <= 8'h00;
         ext_clk_pin <= ~ext_clk_pin;
      end else begin
         half_cnt_r <= half_cnt_r + 8'h01;
      end
   end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
   import clkgc_pkg::*;
   logic              clk_sys, reset, psel, penable, pwrite, want_stop, osc_run;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic              pready, pslverr, stop_mode, ext_clk_pin, int_q, base_q, osc_q, gen_q;
   logic              internal_clock, base_clock, external_clock, osc_out_clock;
   logic              gen_out_clock, bus_clock_en, timebase_clock, watchdog_clock, gen_stop;
   logic              int_gen_enable, ext_gen_enable, pin_osc1_port_en, pin_osc2_port_en;
   logic              filter_stable_flag;
   int                n_errors, comparisons, cyc, n_int, n_base, n_osc, n_gen, n_bus;
   int                n_high, n_tb;
   int                d [7];

   clkgc_top dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_mode(stop_mode), .ext_clk_pin(ext_clk_pin),
      .internal_clock(internal_clock), .base_clock(base_clock),
      .external_clock(external_clock), .osc_out_clock(osc_out_clock),
      .gen_out_clock(gen_out_clock), .bus_clock_en(bus_clock_en),
      .timebase_clock(timebase_clock), .watchdog_clock(watchdog_clock),
      .gen_stop(gen_stop), .int_gen_enable(int_gen_enable), .ext_gen_enable(ext_gen_enable),
      .pin_osc1_port_en(pin_osc1_port_en), .pin_osc2_port_en(pin_osc2_port_en),
      .filter_stable_flag(filter_stable_flag));

   clkgc_far_model far (.clk_sys(clk_sys), .reset(reset), .want_stop(want_stop),
      .osc_run(osc_run), .stop_mode(stop_mode), .ext_clk_pin(ext_clk_pin));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Edge and level counters, read by the tests as deltas
   always @(posedge clk_sys) begin
      cyc++;
      if (internal_clock !== int_q) n_int++;
      if (base_clock !== base_q) n_base++;
      if (osc_out_clock === 1'b1 && osc_q === 1'b0) n_osc++;
      if (gen_out_clock === 1'b1 && gen_q === 1'b0) n_gen++;
      if (bus_clock_en === 1'b1) n_bus++;
      if (internal_clock !== 1'b0 || base_clock !== 1'b0 || external_clock !== 1'b0) n_high++;
      if (timebase_clock !== external_clock || watchdog_clock !== external_clock
          || osc_out_clock !== external_clock) n_tb++;
      int_q = internal_clock;
      base_q = base_clock;
      osc_q = osc_out_clock;
      gen_q = gen_out_clock;
      if (cyc == 90000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, wd, q, e);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(what, q, exp);
   endtask

   task automatic span(input int n);
      int s [7];
      repeat (3) @(negedge clk_sys);
      s = '{n_int, n_base, n_osc, n_gen, n_bus, n_high, n_tb};
      repeat (n) @(negedge clk_sys);
      d = '{n_int-s[0], n_base-s[1], n_osc-s[2], n_gen-s[3], n_bus-s[4], n_high-s[5], n_tb-s[6]};
   endtask

   task automatic ratios;
      check("bus per osc", 32'((d[2] / 4 - d[4]) inside {[-1:1]}), 32'h1);
      check("gen per osc", 32'((d[2] / 2 - d[3]) inside {[-1:1]}), 32'h1);
   endtask

   task automatic t_reset;
      logic [31:0] q;
      logic        e;
      rchk(OFS_CTRL, 32'h1, "ctrl");
      rchk(OFS_CFG, 32'h0, "cfg");
      rchk(OFS_MULT, 32'h1, "mult");
      rchk(OFS_DCO, 32'h800, "dco");
      apb(1'b0, 8'h14, 32'h0, q, e);
      check("unmapped err", 32'(e), 32'h1);
      check("unmapped data", q, 32'h0);
      $display("test reset finished");
   endtask

   task automatic t_lock;
      int          t0, k;
      logic [31:0] q;
      logic        e;
      k = 0;
      while (filter_stable_flag !== 1'b1 && k < 60000) begin
         @(negedge clk_sys);
         k++;
      end
      check("stable flag", 32'(filter_stable_flag), 32'h1);
      k = n_base;
      while (n_base == k) @(negedge clk_sys);
      t0 = cyc;
      while (n_base < k + 9) @(negedge clk_sys);
      check("base half", 32'(((cyc - t0) / 8) inside {[386:427]}), 32'h1);
      apb(1'b0, OFS_DCO, 32'h0, q, e);
      check("dco settled", 32'((q >> 2) inside {[384:427]}), 32'h1);
      $display("test lock finished");
   endtask

   task automatic t_stop;
      wreg(OFS_CTRL, 32'h3);
      rchk(OFS_CTRL, 32'h1, "ext_on refused");
      check("osc1 port", 32'(pin_osc1_port_en), 32'h1);
      wreg(OFS_CFG, 32'h6);
      wreg(OFS_CTRL, 32'h3);
      @(negedge clk_sys);
      check("ext enable", 32'(ext_gen_enable), 32'h1);
      check("osc1 off", 32'(pin_osc1_port_en), 32'h0);
      check("osc2 off", 32'(pin_osc2_port_en), 32'h0);
      rchk(OFS_STAT, 32'h1b, "status");
      @(posedge clk_sys);
      want_stop <= 1'b1;
      osc_run   <= 1'b1;
      span(40);
      check("stop", 32'(gen_stop), 32'h1);
      check("int stopped", 32'(int_gen_enable), 32'h0);
      check("ext stopped", 32'(ext_gen_enable), 32'h0);
      check("clocks low", 32'(d[5]), 32'h0);
      check("osc1 in stop", 32'(pin_osc1_port_en), 32'h0);
      check("osc2 in stop", 32'(pin_osc2_port_en), 32'h0);
      wreg(OFS_CFG, 32'h7);
      @(negedge clk_sys);
      check("run in stop", 32'(gen_stop), 32'h0);
      check("int runs", 32'(int_gen_enable), 32'h1);
      wreg(OFS_CFG, 32'h6);
      @(posedge clk_sys);
      want_stop <= 1'b0;
      repeat (3) @(negedge clk_sys);
      check("stop left", 32'(gen_stop), 32'h0);
      check("ext back", 32'(ext_gen_enable), 32'h1);
      $display("test stop finished");
   endtask

   task automatic t_ext;
      span(400);
      check("timebase", 32'(d[6]), 32'h0);
      check("osc active", 32'(d[2] > 8), 32'h1);
      ratios();
      wreg(OFS_CTRL, 32'h1);
      @(posedge clk_sys);
      osc_run <= 1'b0;
      $display("test ext finished");
   endtask

   task automatic t_div;
      int ns [3] = '{1, 0, 3};
      int m;
      foreach (ns[i]) begin
         wreg(OFS_MULT, 32'(ns[i]));
         m = (ns[i] < 2) ? 1 : ns[i];
         span(6000);
         check("base ticks", 32'(d[1] > 1), 32'h1);
         check("divide", 32'((d[0] / m - d[1]) inside {[-1:1]}), 32'h1);
         ratios();
      end
      wreg(OFS_MULT, 32'h1);
      wreg(OFS_CTRL, 32'h0);
      span(50);
      check("int off low", 32'(d[5]), 32'h0);
      $display("test div finished");
   endtask

   task automatic end_of_test;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, want_stop, osc_run} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_lock();
      t_stop();
      t_ext();
      t_div();
      end_of_test();
   end
endmodule
